/* rtl/vcarb_pkg.sv */
// Function
// - Any software write to a VC arbitration table entry sets the read-only VC table status flag in bit 16.
// - The VC table status flag clears once hardware finishes loading the table after a load request.
// - Writing one to the load-VC-table bit applies the VC table, and that bit always reads as zero.
// - The port arbitration capability field in bits 7:0 reads 19h.
// - Time-based weighted round robin is never allowed on the default channel.
// - The advanced_packet_switching flag in bit 14 reads as zero.
// - The reject-snoop flag in bit 15 reads as zero.
// - The maximum time slots field in bits 22:16 resets to 7Fh.
// - The maximum time slots value may be replaced by an auto-loaded EEPROM value after reset.
// - The port arbitration table offset in bits 31:24 reads 04h, in sixteen_byte_unit steps.
// - Writing one to load-port-table bit 16 applies the port arbitration table.
// - The load-port-table bit is a self-clearing strobe that reads as zero.
// - The port arbitration select field in bits 19:17 accepts only 000b or 011b.
// - Any other select value is stored as 000b.
// - The VC identifier field in bits 26:24 reads 000b.
// - The VC enable bit 31 resets to one and is writable.
// Package for the VC0 arbitration register bank.
// Assumes a 12-bit byte address on a single 250 MHz clock.
package vcarb_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_PVC_STATUS = 12'h14C;
  localparam logic [11:0] OFF_VC0_CAP = 12'h150;
  localparam logic [11:0] OFF_VC0_CTRL = 12'h154;
  localparam int POS_VC_LOAD = 0;
  localparam int POS_VC_TBL_STATUS = 16;
  localparam int POS_PORT_LOAD = 16;
  localparam int POS_ARB_SEL = 17;
  localparam int POS_VC_EN = 31;
  localparam logic [7:0] RST_ARB_CAP = 8'h19;
  localparam logic [6:0] RST_MAX_SLOTS = 7'h7F;
  localparam logic [7:0] RST_TBL_OFFSET = 8'h04;
  localparam logic [7:0] RST_TC_MAP = 8'hFF;
  localparam logic [2:0] RST_VC_ID = 3'h0;
  localparam logic RST_VC_EN = 1'b1;
  localparam logic [2:0] SEL_DEFAULT = 3'h0;
  localparam logic [2:0] SEL_WRR128 = 3'h3;

  typedef struct packed {
    logic vc_en;
    logic [2:0] arb_sel;
    logic [7:0] tc_map;
  } vcarb_ctrl_t;

  typedef enum logic [0:0] {
    VCARB_IDLE = 1'b0,
    VCARB_LOAD = 1'b1
  } vcarb_state_t;

  function automatic logic [2:0] vcarb_sel_filter(input logic [2:0] sel);
    if (sel == SEL_WRR128)
    begin
      return SEL_WRR128;
    end
    return SEL_DEFAULT;
  endfunction : vcarb_sel_filter
endpackage : vcarb_pkg

/* rtl/vcarb_rst_sync.sv */
// Reset synchroniser: asynchronous assert, release after two clock edges.
// Assumes the raw reset may change at any time relative to the clock.
`timescale 1ns/1ps
module vcarb_rst_sync (
  input wire logic i_clock,
  input wire logic i_rstn,
  output logic o_rstn
);
  import vcarb_pkg::*;
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= 1'b1;
      sync_ff <= meta_ff;
    end
  end

  assign o_rstn = sync_ff;
endmodule : vcarb_rst_sync

/* rtl/vcarb_load_seq.sv */
// Table load sequencer: status flag, load strobe and wait for completion.
// Assumes entry-write and done inputs come from logic on the same clock.
`timescale 1ns/1ps
module vcarb_load_seq (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_entry_wr,
  input wire logic i_load_req,
  input wire logic i_load_done,
  output logic o_load,
  output logic o_status,
  output logic o_busy
);
  import vcarb_pkg::*;
  vcarb_state_t state_ff;
  logic load_ff;
  logic status_ff;

  // A request during a load is dropped; the status flag still tells software
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff <= VCARB_IDLE;
    end
    else
    begin
      unique case (state_ff)
        VCARB_IDLE: if (i_load_req) state_ff <= VCARB_LOAD;
        VCARB_LOAD: if (i_load_done) state_ff <= VCARB_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      load_ff <= 1'b0;
    end
    else
    begin
      load_ff <= (state_ff == VCARB_IDLE) && i_load_req;
    end
  end

  // Set wins over clear so a late entry write is never lost
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status_ff <= 1'b0;
    end
    else if (i_entry_wr)
    begin
      status_ff <= 1'b1;
    end
    else if ((state_ff == VCARB_LOAD) && i_load_done)
    begin
      status_ff <= 1'b0;
    end
  end

  assign o_load = load_ff;
  assign o_status = status_ff;
  assign o_busy = (state_ff == VCARB_LOAD);
endmodule : vcarb_load_seq

/* rtl/vcarb_regs.sv */
// VC0 arbitration register bank: port_vc_table_status, VC0 capability and control.
// Assumes a single-cycle strobe register port and table logic on i_clock.
`timescale 1ns/1ps
module vcarb_regs (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_vc_tbl_wr,
  input wire logic i_vc_tbl_done,
  input wire logic i_port_tbl_wr,
  input wire logic i_port_tbl_done,
  input wire logic i_ee_valid,
  input wire logic [6:0] i_ee_max_slots,
  output logic [31:0] o_rdata,
  output vcarb_pkg::vcarb_ctrl_t o_ctrl,
  output logic o_vc_tbl_load,
  output logic o_port_tbl_load,
  output logic o_port_tbl_status
);
  import vcarb_pkg::*;

  logic rstn;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  vcarb_ctrl_t ctrl_ff;
  logic [6:0] max_slots_ff;
  logic vc_status;
  logic vc_busy;
  logic port_busy;
  logic wr_pvc;
  logic wr_ctrl;
  logic vc_load_req;
  logic port_load_req;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction : hit

  vcarb_rst_sync u_rst_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .o_rstn(rstn)
  );

  assign wr_pvc = i_wr && hit(i_addr, OFF_PVC_STATUS);
  assign wr_ctrl = i_wr && hit(i_addr, OFF_VC0_CTRL);
  assign vc_load_req = wr_pvc && i_wdata[POS_VC_LOAD];
  assign port_load_req = wr_ctrl && i_wdata[POS_PORT_LOAD];

  vcarb_load_seq u_vc_seq (
    .i_clock(i_clock),
    .i_rstn(rstn),
    .i_entry_wr(i_vc_tbl_wr),
    .i_load_req(vc_load_req),
    .i_load_done(i_vc_tbl_done),
    .o_load(o_vc_tbl_load),
    .o_status(vc_status),
    .o_busy(vc_busy)
  );

  vcarb_load_seq u_port_seq (
    .i_clock(i_clock),
    .i_rstn(rstn),
    .i_entry_wr(i_port_tbl_wr),
    .i_load_req(port_load_req),
    .i_load_done(i_port_tbl_done),
    .o_load(o_port_tbl_load),
    .o_status(o_port_tbl_status),
    .o_busy(port_busy)
  );

  // Only the writable control fields are stored; reserved bits never land
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_ff.tc_map <= RST_TC_MAP;
      ctrl_ff.arb_sel <= SEL_DEFAULT;
      ctrl_ff.vc_en <= RST_VC_EN;
    end
    else if (wr_ctrl)
    begin
      ctrl_ff.tc_map <= i_wdata[7:0];
      ctrl_ff.arb_sel <= vcarb_sel_filter(i_wdata[POS_ARB_SEL+:3]);
      ctrl_ff.vc_en <= i_wdata[POS_VC_EN];
    end
  end

  // EEPROM auto-load may override the default at any time after reset
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      max_slots_ff <= RST_MAX_SLOTS;
    end
    else if (i_ee_valid)
    begin
      max_slots_ff <= i_ee_max_slots;
    end
  end

  always_comb
  begin
    nxt_rdata = 32'h0;
    if (i_rd)
    begin
      if (hit(i_addr, OFF_PVC_STATUS))
      begin
        nxt_rdata[POS_VC_TBL_STATUS] = vc_status;
      end
      else if (hit(i_addr, OFF_VC0_CAP))
      begin
        nxt_rdata[7:0] = RST_ARB_CAP;
        nxt_rdata[14] = 1'b0;
        nxt_rdata[15] = 1'b0;
        nxt_rdata[22:16] = max_slots_ff;
        nxt_rdata[31:24] = RST_TBL_OFFSET;
      end
      else if (hit(i_addr, OFF_VC0_CTRL))
      begin
        nxt_rdata[7:0] = ctrl_ff.tc_map;
        nxt_rdata[POS_PORT_LOAD] = 1'b0;
        nxt_rdata[POS_ARB_SEL+:3] = ctrl_ff.arb_sel;
        nxt_rdata[26:24] = RST_VC_ID;
        nxt_rdata[POS_VC_EN] = ctrl_ff.vc_en;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise and for unmapped addresses
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= 32'h0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_ctrl = ctrl_ff;

  status_set_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_vc_tbl_wr |=> vc_status
  ) else $error("VC table status not set after entry write");

  status_clear_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    vc_busy && i_vc_tbl_done && !i_vc_tbl_wr |=> !vc_status && !vc_busy
  ) else $error("VC table status not cleared after load done");

  status_hold_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    vc_status && !(vc_busy && i_vc_tbl_done) |=> vc_status
  ) else $error("VC table status cleared without a finished load");

  vc_load_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    vc_load_req && !vc_busy |=> o_vc_tbl_load ##1 !o_vc_tbl_load
  ) else $error("VC table load strobe wrong");

  vc_load_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_PVC_STATUS) |=> o_rdata[POS_VC_LOAD] == 1'b0
  ) else $error("Load VC table bit read back as one");

  arb_cap_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CAP) |=> o_rdata[7:0] == 8'h19
  ) else $error("Port arbitration capability not 19h");

  sel_filter_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    wr_ctrl && i_wdata[19:17] != 3'h3 |=> o_ctrl.arb_sel == 3'h0
  ) else $error("Unsupported arbitration select stored");

  sel_keep_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    wr_ctrl && i_wdata[19:17] == 3'h3 |=> o_ctrl.arb_sel == 3'h3
  ) else $error("Weighted round robin select not stored");

  cap_flags_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CAP) |=> o_rdata[15:8] == 8'h0 && o_rdata[23] == 1'b0
  ) else $error("Capability flag or reserved bits set");

  max_slots_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_ee_valid ##1 (i_rd && hit(i_addr, OFF_VC0_CAP) && !i_ee_valid)
      |=> o_rdata[22:16] == $past(i_ee_max_slots, 2)
  ) else $error("Auto-loaded maximum time slots not reported");

  tbl_offset_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CAP) |=> o_rdata[31:24] == 8'h04
  ) else $error("Port arbitration table offset not 04h");

  port_load_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    port_load_req && !port_busy |=> o_port_tbl_load ##1 !o_port_tbl_load
  ) else $error("Port table load strobe wrong");

  port_load_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CTRL) |=> o_rdata[16] == 1'b0 && o_rdata[26:24] == 3'h0
  ) else $error("Load bit or VC identifier read back nonzero");

  vc_enable_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    wr_ctrl |=> o_ctrl.vc_en == $past(i_wdata[31]) && o_ctrl.tc_map == $past(i_wdata[7:0])
  ) else $error("VC enable or traffic_class_channel_map not stored");

  reserved_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CTRL) |=> o_rdata[15:8] == 8'h0 && o_rdata[23:20] == 4'h0
      && o_rdata[30:27] == 4'h0
  ) else $error("Reserved control bits read nonzero");

  status_rsvd_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_PVC_STATUS) |=> o_rdata[31:17] == 15'h0 && o_rdata[15:0] == 16'h0
  ) else $error("Reserved status bits read nonzero");

  idle_rdata_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !i_rd |=> o_rdata == 32'h0
  ) else $error("Read data driven without a read");

  status_low_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !vc_status && !i_vc_tbl_wr |=> !vc_status
  ) else $error("VC table status set without an entry write");

  status_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_PVC_STATUS) |=> o_rdata[16] == $past(vc_status)
  ) else $error("VC table status read back wrong");

  vc_busy_hold_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    vc_busy && !i_vc_tbl_done |=> vc_busy
  ) else $error("VC table load ended without done");

  vc_load_drop_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    vc_load_req && vc_busy |=> !o_vc_tbl_load
  ) else $error("VC table load strobe during a pending load");

  vc_load_only_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !vc_load_req |=> !o_vc_tbl_load
  ) else $error("VC table load strobe without a request");

  vc_load_busy_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    o_vc_tbl_load |-> vc_busy
  ) else $error("VC table load strobe outside a load");

  vc_load_once_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    o_vc_tbl_load |=> !o_vc_tbl_load
  ) else $error("VC table load strobe longer than one cycle");

  port_status_set_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_port_tbl_wr |=> o_port_tbl_status
  ) else $error("Port table status not set after entry write");

  port_status_clear_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    port_busy && i_port_tbl_done && !i_port_tbl_wr |=> !o_port_tbl_status && !port_busy
  ) else $error("Port table status not cleared after load done");

  port_flag_low_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !o_port_tbl_status && !i_port_tbl_wr |=> !o_port_tbl_status
  ) else $error("Port table status set without an entry write");

  port_busy_hold_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    port_busy && !i_port_tbl_done |=> port_busy
  ) else $error("Port table load ended without done");

  port_load_drop_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    port_load_req && port_busy |=> !o_port_tbl_load
  ) else $error("Port table load strobe during a pending load");

  port_load_only_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !port_load_req |=> !o_port_tbl_load
  ) else $error("Port table load strobe without a request");

  port_load_busy_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    o_port_tbl_load |-> port_busy
  ) else $error("Port table load strobe outside a load");

  port_load_once_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    o_port_tbl_load |=> !o_port_tbl_load
  ) else $error("Port table load strobe longer than one cycle");

  sel_legal_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    (ctrl_ff.arb_sel == 3'h0) || (ctrl_ff.arb_sel == 3'h3)
  ) else $error("Illegal arbitration select held");

  ctrl_hold_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !wr_ctrl |=> $stable(ctrl_ff)
  ) else $error("Control fields changed without a control write");

  ctrl_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CTRL) |=> o_rdata[7:0] == $past(ctrl_ff.tc_map)
      && o_rdata[19:17] == $past(ctrl_ff.arb_sel) && o_rdata[31] == $past(ctrl_ff.vc_en)
  ) else $error("Control fields read back wrong");

  slots_hold_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    !i_ee_valid |=> $stable(max_slots_ff)
  ) else $error("Maximum time slots changed without auto-load");

  ee_load_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_ee_valid |=> max_slots_ff == $past(i_ee_max_slots)
  ) else $error("Auto-loaded maximum time slots not taken");

  slots_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && hit(i_addr, OFF_VC0_CAP) |=> o_rdata[22:16] == $past(max_slots_ff)
  ) else $error("Maximum time slots read back wrong");

  unmapped_read_a: assert property (
    @(posedge i_clock) disable iff (!rstn)
    i_rd && !hit(i_addr, OFF_PVC_STATUS) && !hit(i_addr, OFF_VC0_CAP) && !hit(i_addr, OFF_VC0_CTRL)
      |=> o_rdata == 32'h0
  ) else $error("Unmapped address read nonzero");
endmodule : vcarb_regs

/* tb/vcarb_regs_bench.sv */
// Self-checking bench for the VC0 arbitration register bank.
// Assumes the single-cycle strobe register port and the table handshakes of vcarb_regs.
`timescale 1ns/1ps
module vcarb_regs_bench;
  import vcarb_pkg::*;
  logic i_clock;
  logic i_rstn;
  logic i_wr;
  logic i_rd;
  logic [11:0] i_addr;
  logic [31:0] i_wdata;
  logic i_vc_tbl_wr;
  logic i_vc_tbl_done;
  logic i_port_tbl_wr;
  logic i_port_tbl_done;
  logic i_ee_valid;
  logic [6:0] i_ee_max_slots;
  logic [31:0] o_rdata;
  vcarb_ctrl_t o_ctrl;
  logic o_vc_tbl_load;
  logic o_port_tbl_load;
  logic o_port_tbl_status;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] e;
  logic [6:0] slots;
  int num_errors;
  int checks_done;

  vcarb_regs vcarb_regs_i (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_vc_tbl_wr(i_vc_tbl_wr),
    .i_vc_tbl_done(i_vc_tbl_done),
    .i_port_tbl_wr(i_port_tbl_wr),
    .i_port_tbl_done(i_port_tbl_done),
    .i_ee_valid(i_ee_valid),
    .i_ee_max_slots(i_ee_max_slots),
    .o_rdata(o_rdata),
    .o_ctrl(o_ctrl),
    .o_vc_tbl_load(o_vc_tbl_load),
    .o_port_tbl_load(o_port_tbl_load),
    .o_port_tbl_status(o_port_tbl_status)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Strobe released at the taking edge; the trailing delay lets registered outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= w;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask : rd

  task automatic pulse(input int which);
    @(posedge i_clock);
    case (which)
      0: i_vc_tbl_wr <= 1'b1;
      1: i_vc_tbl_done <= 1'b1;
      2: i_port_tbl_wr <= 1'b1;
      3: i_port_tbl_done <= 1'b1;
      default: i_ee_valid <= 1'b1;
    endcase
    @(posedge i_clock);
    {i_vc_tbl_wr, i_vc_tbl_done, i_port_tbl_wr, i_port_tbl_done, i_ee_valid} <= 5'h00;
    #1;
  endtask : pulse

  // Expected control word read back: strobe reads zero, VC ID and reserved bits zero
  function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
    logic [2:0] sel;
    sel = (w[19:17] == 3'h3) ? 3'h3 : 3'h0;
    return {w[31], 7'h00, 4'h0, sel, 1'b0, 8'h00, w[7:0]};
  endfunction : exp_ctrl

  // Watchdog against a hung run
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end

  initial
  begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    {i_vc_tbl_wr, i_vc_tbl_done, i_port_tbl_wr, i_port_tbl_done, i_ee_valid} = 5'h00;
    i_ee_max_slots = 7'h00;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(7108));
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    rd(OFF_VC0_CAP, r);
    check("capability", r, 32'h047F_0019);
    rd(OFF_VC0_CTRL, r);
    check("control", r, 32'h8000_00FF);
    check("control port", {20'h0_0000, o_ctrl}, 32'h0000_08FF);
    rd(OFF_PVC_STATUS, r);
    check("vc status", r, 32'h0000_0000);
    rd(12'h158, r);
    check("unmapped", r, 32'h0000_0000);
    wr(OFF_VC0_CAP, $urandom);
    rd(OFF_VC0_CAP, r);
    check("capability after write", r, 32'h047F_0019);
    // VC table: entry write, load request, completion
    pulse(0);
    rd(OFF_PVC_STATUS, r);
    check("vc status set", r, 32'h0001_0000);
    wr(OFF_PVC_STATUS, 32'hFFFF_FFFF);
    check("vc load", {31'h0, o_vc_tbl_load}, 32'h1);
    @(posedge i_clock);
    #1;
    check("vc load end", {31'h0, o_vc_tbl_load}, 32'h0);
    rd(OFF_PVC_STATUS, r);
    check("vc status pending", r, 32'h0001_0000);
    pulse(1);
    rd(OFF_PVC_STATUS, r);
    check("vc status cleared", r, 32'h0000_0000);
    // Port table and every select code, twice over with random fields
    pulse(2);
    check("port status", {31'h0, o_port_tbl_status}, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom;
      d[19:17] = i[2:0];
      d[16] = 1'b1;
      e = exp_ctrl(d);
      wr(OFF_VC0_CTRL, d);
      check("port load", {31'h0, o_port_tbl_load}, 32'h1);
      check("control port", {20'h0_0000, o_ctrl}, {20'h0_0000, e[31], e[19:17], e[7:0]});
      @(posedge i_clock);
      #1;
      check("port load end", {31'h0, o_port_tbl_load}, 32'h0);
      rd(OFF_VC0_CTRL, r);
      check("control", r, e);
      pulse(3);
    end
    check("port status cleared", {31'h0, o_port_tbl_status}, 32'h0);
    // Auto-loaded maximum time slots, read back in the very next cycle
    @(posedge i_clock);
    slots = 7'($urandom);
    i_ee_max_slots <= slots;
    i_ee_valid <= 1'b1;
    @(posedge i_clock);
    i_ee_valid <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= OFF_VC0_CAP;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    check("slots loaded", o_rdata, {8'h04, 1'b0, slots, 16'h0019});
    // Second reset in mid-run must bring back the capability and control defaults
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    rd(OFF_VC0_CAP, r);
    check("capability after reset", r, 32'h047F_0019);
    rd(OFF_VC0_CTRL, r);
    check("control after reset", r, 32'h8000_00FF);
    close_out();
  end
endmodule : vcarb_regs_bench
